// ===== rsip_consts.svh
// Constants for the reset, strap and attention pin block
`ifndef RSIP_CONSTS_SVH
`define RSIP_CONSTS_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define RSIP_CLK_MHZ          125
`define RSIP_RST_MIN_NS       2000
`define RSIP_RST_MIN_CYC      ((`RSIP_RST_MIN_NS * `RSIP_CLK_MHZ + 999) / 1000)
`define RSIP_SETTLE_MS        150
`define RSIP_SETTLE_CYC       (`RSIP_SETTLE_MS * 1000 * `RSIP_CLK_MHZ)
`define RSIP_BLINK_CYC        6250000

// ---------------------------------------------------------------
// Strap values and event field positions
// ---------------------------------------------------------------
`define RSIP_MODE_NORMAL      3'h7
`define RSIP_EVT_CONNECT      0
`define RSIP_EVT_DISCON       1
`define RSIP_EVT_RECV         2
`define RSIP_EVT_TIMEOUT      3
`define RSIP_EVT_WAKE         4
`define RSIP_EVT_W            5
`define RSIP_MASK_RST         5'h00

`endif

// ===== rsip_pkg.sv
// Types shared by the reset, strap and attention pin block
package rsip_pkg;

  // Straps captured at reset release
  typedef struct packed {
    logic       autoneg;
    logic       full_duplex;
    logic       rate_100;
    logic [2:0] mode;
  } rsip_straps_t;

  // Link status feeding the indicator pins
  typedef struct packed {
    logic linked;
    logic activity;
    logic full_duplex;
    logic rate_100;
  } rsip_link_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    RSIP_ST_HELD,
    RSIP_ST_SETTLE,
    RSIP_ST_RUN
  } rsip_state_t;

endpackage : rsip_pkg

// ===== rsip_event_latch.sv
// Sticky event bits with per-source masks and clear
`timescale 1ns/100ps
`include "rsip_consts.svh"

module rsip_event_latch #(
  parameter int WIDTH = `RSIP_EVT_W
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Event sources and host control
  input  wire logic [WIDTH-1:0] event_pulse,
  input  wire logic [WIDTH-1:0] clear_bits,
  input  wire logic [WIDTH-1:0] mask_bits,
  // Pending state
  output logic      [WIDTH-1:0] pending,
  output logic                  any_unmasked
);
  import rsip_pkg::*;

  logic [WIDTH-1:0] next_pending;

  // ---------------------------------------------------------------
  // Sticky bits: a new event beats a clear in the same cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_pending = pending;
    for (int i = 0; i < WIDTH; i++) begin
      if (event_pulse[i]) begin
        next_pending[i] = 1'b1;
      end else if (clear_bits[i]) begin
        next_pending[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  assign any_unmasked = |(pending & mask_bits);

  AST_CLEAR_DROPS: assert property (@(posedge sys_clk) disable iff (rst)
    (clear_bits == {WIDTH{1'b1}} && event_pulse == '0) |=> !any_unmasked)
    else $error("pending survived a full clear");

  AST_MASK_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
    (mask_bits == '0) |-> !any_unmasked)
    else $error("masked event reached attention");

endmodule : rsip_event_latch

// ===== rsip_led_drive.sv
// Active-low status indicators with activity blink
`timescale 1ns/100ps
`include "rsip_consts.svh"

module rsip_led_drive #(
  parameter int BLINK_CYC = `RSIP_BLINK_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Link state
  input  wire rsip_pkg::rsip_link_t link,
  // Indicator levels, active low
  output logic                   duplex_n,
  output logic                   rate_n,
  output logic                   link_n
);
  import rsip_pkg::*;

  logic [31:0] blink_cnt;
  logic        blink_ph;
  logic [31:0] next_blink_cnt;
  logic        next_blink_ph;
  logic        next_duplex_n;
  logic        next_rate_n;
  logic        next_link_n;

  // ---------------------------------------------------------------
  // Blink timer runs only with activity so the light stays steady idle
  // ---------------------------------------------------------------
  always_comb begin
    next_blink_cnt = blink_cnt;
    next_blink_ph  = blink_ph;
    if (!link.activity) begin
      next_blink_cnt = '0;
      next_blink_ph  = 1'b0;
    end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
      next_blink_cnt = '0;
      next_blink_ph  = ~blink_ph;
    end else begin
      next_blink_cnt = blink_cnt + 32'h1;
    end
    next_duplex_n = ~link.full_duplex;
    next_rate_n   = ~link.rate_100;
    next_link_n   = ~(link.linked & ~next_blink_ph);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blink_cnt <= '0;
      blink_ph  <= 1'b0;
      duplex_n  <= 1'b1;
      rate_n    <= 1'b1;
      link_n    <= 1'b1;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink_ph  <= next_blink_ph;
      duplex_n  <= next_duplex_n;
      rate_n    <= next_rate_n;
      link_n    <= next_link_n;
    end
  end

  AST_LINK_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !link.linked |=> link_n)
    else $error("link light on without link");

endmodule : rsip_led_drive

// ===== rsip_pin_ctrl.sv
// Reset sequencing, strap capture, attention, power-down and select gating
`timescale 1ns/100ps
`include "rsip_consts.svh"

// Overview of operation
// - Low hard reset initialises all state except the straps, which hold until recaptured at release; reasserting reinitialises it.
// - Attention goes low on connect, disconnect, receive, timeout or wake event.
// - Host clears events by writing; attention releases when no unmasked event.
// - Each event source has its own mask; masked sources never assert attention.
// - Sleep request high enters power-down; low runs normally.
// - Autonegotiation strap high enables autonegotiation, low disables it.
// - Duplex strap low half, high full; taken in reset, held afterwards.
// - Rate strap high selects 100M, low 10M; honoured only in reset.
// - Mode straps sampled in reset; 111 normal, other patterns test mode.
// - Serial slave port answers only while slave select is low.
// - After reset shared strap pins become active-low duplex, rate, link lights.
module rsip_pin_ctrl #(
  parameter int SETTLE_CYC = `RSIP_SETTLE_CYC,
  parameter int BLINK_CYC  = `RSIP_BLINK_CYC,
  parameter int EVT_W      = `RSIP_EVT_W
) (
  // Clock and synchronous reset of the logic itself
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Host pins
  input  wire logic             hard_reset_in_n,
  input  wire logic             slave_select_in_n,
  input  wire logic             sleep_request_in,
  output logic                  attention_out_n,
  // Strap inputs
  input  wire logic             autoneg_strap,
  input  wire logic             full_half_strap,
  input  wire logic             link_rate_strap,
  // Shared mode strap / indicator pins
  input  wire logic             mode_strap_hi_in,
  input  wire logic             mode_strap_mid_in,
  input  wire logic             mode_strap_lo_in,
  output logic                  duplex_led_n,
  output logic                  rate_led_n,
  output logic                  link_led_n,
  output logic                  led_oe,
  // Event sources from the protocol core, one-cycle pulses
  input  wire logic [EVT_W-1:0] event_pulse,
  // Host writes to the common or socket event registers
  input  wire logic [EVT_W-1:0] common_event_reg_clear,
  input  wire logic [EVT_W-1:0] socket_event_reg_clear,
  input  wire logic [EVT_W-1:0] event_mask,
  output logic      [EVT_W-1:0] event_pending,
  // Link state from the transceiver
  input  wire logic             phy_linked,
  input  wire logic             phy_activity,
  // Status and control to the core
  output rsip_pkg::rsip_straps_t straps,
  output logic                  test_mode,
  output logic                  core_reset,
  output logic                  host_ready,
  output logic                  power_down,
  output logic                  spi_enable
);
  import rsip_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rsip_state_t  state;
  rsip_state_t  next_state;
  logic [31:0]  settle_cnt;
  logic [31:0]  next_settle_cnt;
  rsip_straps_t next_straps;
  logic         next_led_oe;
  logic         next_power_down;
  logic         any_unmasked;
  logic         next_attention_n;
  logic         in_reset;
  rsip_link_t   link;
  logic         led_duplex_n;
  logic         led_rate_n;
  logic         led_link_n;

  // Reset pin or local reset holds everything
  assign in_reset = rst | ~hard_reset_in_n;

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    next_straps     = straps;
    next_led_oe     = led_oe;
    unique case (state)
      RSIP_ST_HELD: begin
        next_led_oe     = 1'b0;
        next_settle_cnt = '0;
        if (hard_reset_in_n) begin
          next_straps.autoneg     = autoneg_strap;
          next_straps.full_duplex = full_half_strap;
          next_straps.rate_100    = link_rate_strap;
          next_straps.mode        = {mode_strap_hi_in, mode_strap_mid_in, mode_strap_lo_in};
          next_state              = RSIP_ST_SETTLE;
        end
      end
      RSIP_ST_SETTLE: begin
        next_led_oe = 1'b1;
        if (settle_cnt == 32'(SETTLE_CYC - 1)) begin
          next_state = RSIP_ST_RUN;
        end else begin
          next_settle_cnt = settle_cnt + 32'h1;
        end
      end
      RSIP_ST_RUN: begin
        next_led_oe = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= RSIP_ST_HELD;
      settle_cnt <= '0;
      straps     <= '0;
      led_oe     <= 1'b0;
    end else if (!hard_reset_in_n) begin
      state      <= RSIP_ST_HELD;
      settle_cnt <= '0;
      straps     <= straps;
      led_oe     <= 1'b0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
      straps     <= next_straps;
      led_oe     <= next_led_oe;
    end
  end

  // Core held until the sequencer leaves the held state
  assign core_reset = (state == RSIP_ST_HELD);
  assign host_ready = (state == RSIP_ST_RUN);
  assign test_mode  = (straps.mode != `RSIP_MODE_NORMAL);

  // ---------------------------------------------------------------
  // Power-down and select gating
  // ---------------------------------------------------------------
  always_comb begin
    next_power_down = sleep_request_in & ~core_reset;
  end

  always_ff @(posedge sys_clk) begin
    if (in_reset) begin
      power_down <= 1'b0;
    end else begin
      power_down <= next_power_down;
    end
  end

  // respond only when selected; asleep or held port stays deaf
  assign spi_enable = ~slave_select_in_n & ~core_reset & ~power_down;

  // ---------------------------------------------------------------
  // Event latch and attention output
  // ---------------------------------------------------------------
  // events set pending
  rsip_event_latch #(
    .WIDTH        (EVT_W)
  ) u_events (
    .sys_clk      (sys_clk),
    .rst          (in_reset),
    .event_pulse  (event_pulse),
    .clear_bits   (common_event_reg_clear | socket_event_reg_clear),
    .mask_bits    (event_mask),
    .pending      (event_pending),
    .any_unmasked (any_unmasked)
  );

  always_comb begin
    next_attention_n = ~any_unmasked;
  end

  always_ff @(posedge sys_clk) begin
    if (in_reset) begin
      attention_out_n <= 1'b1;
    end else begin
      attention_out_n <= next_attention_n;
    end
  end

  // ---------------------------------------------------------------
  // Indicator pins, live only after capture
  // ---------------------------------------------------------------
  // Duplex and rate lights follow the captured straps; autoneg result is not modelled
  assign link.linked      = phy_linked;
  assign link.activity    = phy_activity & phy_linked;
  assign link.full_duplex = straps.full_duplex;
  assign link.rate_100    = straps.rate_100;

  rsip_led_drive #(
    .BLINK_CYC (BLINK_CYC)
  ) u_leds (
    .sys_clk   (sys_clk),
    .rst       (in_reset),
    .link      (link),
    .duplex_n  (led_duplex_n),
    .rate_n    (led_rate_n),
    .link_n    (led_link_n)
  );

  assign duplex_led_n = led_oe ? led_duplex_n : 1'b1;
  assign rate_led_n   = led_oe ? led_rate_n   : 1'b1;
  assign link_led_n   = led_oe ? led_link_n   : 1'b1;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_RESET_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
    !hard_reset_in_n |=> (core_reset && !led_oe && attention_out_n))
    else $error("state not held under hard reset");

  AST_CAPTURE_DUPLEX: assert property (@(posedge sys_clk) disable iff (rst)
    (state == RSIP_ST_HELD && hard_reset_in_n) |=> (straps.full_duplex == $past(full_half_strap)))
    else $error("duplex strap not captured at release");

  AST_STRAP_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (state != RSIP_ST_HELD && hard_reset_in_n) |=> $stable(straps))
    else $error("straps changed outside reset");

  AST_AUTONEG: assert property (@(posedge sys_clk) disable iff (rst)
    (state == RSIP_ST_HELD && hard_reset_in_n) |=> (straps.autoneg == $past(autoneg_strap)))
    else $error("autoneg strap not captured");

  AST_TEST_MODE: assert property (@(posedge sys_clk) disable iff (rst)
    test_mode == (straps.mode != 3'h7))
    else $error("mode decode wrong");

  AST_OE_AFTER: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(led_oe) |-> ($past(state) == RSIP_ST_SETTLE || $past(state) == RSIP_ST_HELD) && !core_reset)
    else $error("pins driven before capture");

  AST_ATTN_EVENT: assert property (@(posedge sys_clk) disable iff (in_reset)
    (|(event_pulse & event_mask)) |=> ##1 !attention_out_n)
    else $error("unmasked event did not raise attention");

  AST_SLEEP: assert property (@(posedge sys_clk) disable iff (in_reset)
    (sleep_request_in && !core_reset) |=> power_down)
    else $error("sleep request ignored");

  AST_SELECT: assert property (@(posedge sys_clk) disable iff (rst)
    slave_select_in_n |-> !spi_enable)
    else $error("port active without select");

  AST_CAPTURE_RATE: assert property (@(posedge sys_clk) disable iff (rst)
    (state == RSIP_ST_HELD && hard_reset_in_n) |=> (straps.rate_100 == $past(link_rate_strap)))
    else $error("rate strap not captured at release");

  AST_CAPTURE_MODE: assert property (@(posedge sys_clk) disable iff (rst)
    (state == RSIP_ST_HELD && hard_reset_in_n) |=>
      (straps.mode == {$past(mode_strap_hi_in), $past(mode_strap_mid_in),
                       $past(mode_strap_lo_in)}))
    else $error("mode straps not captured at release");

  AST_READY_LATE: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(host_ready) |-> ($past(settle_cnt) == 32'(SETTLE_CYC - 1)))
    else $error("ready before settling count ran out");

  AST_OE_HELD: assert property (@(posedge sys_clk) disable iff (rst)
    core_reset |=> !led_oe)
    else $error("pins driven while held");

  AST_DUPLEX_LIGHT: assert property (@(posedge sys_clk) disable iff (rst)
    led_oe |-> (duplex_led_n == !straps.full_duplex))
    else $error("duplex light disagrees with strap");

  AST_RATE_LIGHT: assert property (@(posedge sys_clk) disable iff (rst)
    led_oe |-> (rate_led_n == !straps.rate_100))
    else $error("rate light disagrees with strap");

  AST_LIGHTS_DARK: assert property (@(posedge sys_clk) disable iff (rst)
    !led_oe |-> (duplex_led_n && rate_led_n && link_led_n))
    else $error("light driven before pins released");

  AST_AWAKE: assert property (@(posedge sys_clk) disable iff (in_reset)
    !sleep_request_in |=> !power_down)
    else $error("power-down without request");

  AST_SELECT_ON: assert property (@(posedge sys_clk) disable iff (rst)
    (!slave_select_in_n && !core_reset && !power_down) |-> spi_enable)
    else $error("selected port not enabled");

  AST_ATTN_RELEASE: assert property (@(posedge sys_clk) disable iff (in_reset)
    ((event_pending & event_mask) == '0) |=> attention_out_n)
    else $error("attention held with nothing unmasked pending");

endmodule : rsip_pin_ctrl

// ===== rsip_host_model.sv
// Host controller model: reset, select, sleep and event clears
`timescale 1ns/100ps
`include "rsip_consts.svh"

module rsip_host_model #(
  parameter int SETTLE_CYC = 20
) (
  // Clock and device status
  input  wire logic                   sys_clk,
  input  wire logic                   host_ready,
  // Host-driven pins
  output logic                        hard_reset_in_n,
  output logic                        slave_select_in_n,
  output logic                        sleep_request_in,
  output logic [`RSIP_EVT_W-1:0]      common_clr,
  output logic [`RSIP_EVT_W-1:0]      socket_clr
);
  // Idle pins at power-up
  initial begin
    hard_reset_in_n   = 1'b1;
    slave_select_in_n = 1'b1;
    sleep_request_in  = 1'b0;
    common_clr        = '0;
    socket_clr        = '0;
  end

  task automatic pulse_reset();
    @(posedge sys_clk) hard_reset_in_n <= 1'b0;
    repeat (`RSIP_RST_MIN_CYC) @(posedge sys_clk);
    hard_reset_in_n <= 1'b1;
  endtask : pulse_reset

  task automatic settle_wait();
    repeat (SETTLE_CYC + 4) @(posedge sys_clk);
  endtask : settle_wait

  task automatic clear_events(input logic [`RSIP_EVT_W-1:0] bits, input logic sock);
    @(posedge sys_clk);
    if (sock) begin
      socket_clr <= bits;
    end else begin
      common_clr <= bits;
    end
    @(posedge sys_clk);
    socket_clr <= '0;
    common_clr <= '0;
  endtask : clear_events

  task automatic set_select(input logic on);
    @(posedge sys_clk) slave_select_in_n <= !(on && host_ready);
  endtask : set_select

  task automatic set_sleep(input logic on);
    @(posedge sys_clk) sleep_request_in <= on;
  endtask : set_sleep
endmodule : rsip_host_model

// ===== rsip_tb.sv
// Self-checking testbench for the reset, strap and attention pin block
`timescale 1ns/100ps
`include "rsip_consts.svh"

module testbench;
  import rsip_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int LIMIT = 4000;
  logic                   sys_clk, rst, hrst_n, sel_n, sleep;
  logic                   attention_out_n, led_oe, test_mode, core_reset;
  logic                   host_ready, power_down, spi_enable;
  logic                   autoneg_strap, full_half_strap, link_rate_strap;
  logic                   m_hi, m_mid, m_lo, duplex_led_n, rate_led_n, link_led_n;
  logic                   phy_linked, phy_activity;
  logic [`RSIP_EVT_W-1:0] event_pulse, cclr, sclr, event_mask, event_pending;
  rsip_straps_t           straps;
  int                     err_count, check_count, cyc, lows;

  // Clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  rsip_pin_ctrl #(.SETTLE_CYC(20), .BLINK_CYC(4)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .hard_reset_in_n(hrst_n),
    .slave_select_in_n(sel_n), .sleep_request_in(sleep),
    .attention_out_n(attention_out_n), .autoneg_strap(autoneg_strap),
    .full_half_strap(full_half_strap), .link_rate_strap(link_rate_strap),
    .mode_strap_hi_in(m_hi), .mode_strap_mid_in(m_mid), .mode_strap_lo_in(m_lo),
    .duplex_led_n(duplex_led_n), .rate_led_n(rate_led_n), .link_led_n(link_led_n),
    .led_oe(led_oe), .event_pulse(event_pulse), .common_event_reg_clear(cclr),
    .socket_event_reg_clear(sclr), .event_mask(event_mask),
    .event_pending(event_pending), .phy_linked(phy_linked),
    .phy_activity(phy_activity), .straps(straps), .test_mode(test_mode),
    .core_reset(core_reset), .host_ready(host_ready), .power_down(power_down),
    .spi_enable(spi_enable));

  rsip_host_model #(.SETTLE_CYC(20)) u_host (
    .sys_clk(sys_clk), .host_ready(host_ready), .hard_reset_in_n(hrst_n),
    .slave_select_in_n(sel_n), .sleep_request_in(sleep),
    .common_clr(cclr), .socket_clr(sclr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Wait edges, then sample once settled
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic pulse(input logic [`RSIP_EVT_W-1:0] v);
    @(posedge sys_clk) event_pulse <= v;
    @(posedge sys_clk) event_pulse <= '0;
    step(2);
  endtask : pulse

  // Mask and link levels change just after an edge
  task automatic set_mask(input logic [`RSIP_EVT_W-1:0] m);
    @(posedge sys_clk) event_mask <= m;
  endtask : set_mask

  task automatic set_link(input logic [1:0] v);
    @(posedge sys_clk) {phy_linked, phy_activity} <= v;
  endtask : set_link

  // Hard reset with a strap pattern, then disturb the straps
  task automatic strap_run(input logic [5:0] s);
    @(posedge sys_clk);
    {autoneg_strap, full_half_strap, link_rate_strap, m_hi, m_mid, m_lo} <= s;
    u_host.pulse_reset();
    step(1);
    chk(8'(straps), 8'(s), "captured straps");
    chk(8'(test_mode), 8'(s[2:0] != 3'h7), "test mode");
    chk(8'({core_reset, led_oe, host_ready}), 8'h0, "run, pins not yet out");
    chk(8'({attention_out_n, event_pending}), 8'h20, "state reinit");
    step(2);
    chk(8'({led_oe, duplex_led_n, rate_led_n}), 8'({1'b1, ~s[4], ~s[3]}), "lights");
    @(posedge sys_clk);
    {full_half_strap, link_rate_strap, m_hi, m_mid, m_lo} <= ~s[4:0];
    step(2);
    chk(8'(straps[4:0]), 8'(s[4:0]), "straps kept");
    u_host.settle_wait();
    step(0);
    chk(8'(host_ready), 8'h1, "ready after settle");
    $display("test strap_run %b done", s);
  endtask : strap_run

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Timeout guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {autoneg_strap, full_half_strap, link_rate_strap, m_hi, m_mid, m_lo} = '0;
    {phy_linked, phy_activity} = '0;
    event_pulse = '0;
    event_mask = '0;
    {err_count, check_count, cyc, lows} = '0;
    step(4);
    chk(8'({attention_out_n, led_oe, core_reset}), 8'h5, "after rst");
    chk(8'(straps), 8'h0, "straps after rst");
    @(posedge sys_clk) rst <= 1'b0;
    strap_run(6'b110111);
    // Every event source: raised and cleared, then masked, unmasked and cleared
    for (int b = 0; b < `RSIP_EVT_W; b++) begin
      set_mask(5'h1f);
      pulse(5'h01 << b);
      chk(8'({attention_out_n, event_pending}), 8'(5'h01 << b), "event raised");
      u_host.clear_events(5'h01 << b, b[0]);
      step(2);
      chk(8'({attention_out_n, event_pending}), 8'h20, "event cleared");
      set_mask(~(5'h01 << b));
      pulse(5'h01 << b);
      chk(8'({attention_out_n, event_pending}), 8'(6'h20 | (5'h01 << b)), "masked");
      set_mask(5'h1f);
      step(3);
      chk(8'(attention_out_n), 8'h0, "unmasked");
      u_host.clear_events(5'h01 << b, !b[0]);
      step(2);
      chk(8'({attention_out_n, event_pending}), 8'h20, "cleared again");
    end
    // Two pending, one cleared: attention must hold
    pulse(5'h03);
    u_host.clear_events(5'h01, 1'b0);
    step(2);
    chk(8'({attention_out_n, event_pending}), 8'h02, "one left");
    u_host.clear_events(5'h1f, 1'b1);
    step(2);
    chk(8'(attention_out_n), 8'h1, "all cleared");
    // Masked source stays silent until unmasked
    set_mask(5'h1e);
    pulse(5'h01);
    chk(8'({attention_out_n, event_pending}), 8'h21, "masked event");
    set_mask(5'h1f);
    step(3);
    chk(8'(attention_out_n), 8'h0, "unmasked event");
    $display("test events done");
    // Select and sleep
    u_host.set_select(1'b1);
    step(1);
    chk(8'(spi_enable), 8'h1, "selected");
    u_host.set_sleep(1'b1);
    step(1);
    chk(8'({power_down, spi_enable}), 8'h2, "asleep");
    u_host.set_sleep(1'b0);
    step(1);
    chk(8'({power_down, spi_enable}), 8'h1, "awake");
    u_host.set_select(1'b0);
    step(1);
    chk(8'(spi_enable), 8'h0, "deselected");
    $display("test select_sleep done");
    // Link light, steady then blinking
    set_link(2'b10);
    step(3);
    chk(8'(link_led_n), 8'h0, "linked");
    set_link(2'b11);
    step(2);
    for (int i = 0; i < 16; i++) begin
      step(1);
      lows += (link_led_n === 1'b0);
    end
    chk(8'(lows), 8'd8, "blink duty");
    set_link(2'b00);
    step(3);
    chk(8'(link_led_n), 8'h1, "unlinked");
    $display("test lights done");
    // Second hard reset drops the pending event
    strap_run(6'b001101);
    // Third reset drives the straps that were always high low
    strap_run(6'b010010);
    results();
  end
endmodule : testbench
